// ==== test/fes_regbank_asserts.sv ====
// ----------------------------------------
// Port checker for the register bank
// ----------------------------------------
module fes_regbank_chk
    import fes_pkg::*;
#(
    parameter int PAGE_BITS = 7    // Same page width as the bank
)
(
    input wire logic               sys_clk,
    input wire logic               rst_n,
    input wire logic [7:0]         sfr_addr,
    input wire logic [7:0]         sfr_wdata,
    input wire logic               sfr_wr,
    input wire logic               sfr_rd,
    input wire logic [7:0]         sfr_rdata,
    input wire logic               irq_global_en,
    input wire logic               debug_en,
    input wire logic               flash_byte_done,
    input wire logic               transfer_busy_event,
    input wire logic [6:0]         ext_irq_lines,
    input wire fes_pkg::fes_wipe_t wipe_start,
    input wire logic               movx_to_flash,
    input wire logic               secure_lock,
    input wire logic               rom_transmit_start,
    input wire logic               watchdog_kick
);
    // Decoded write strobes, named so the properties stay short
    wire wr_trig = sfr_wr && sfr_addr == 8'h94;
    wire wr_ctrl = sfr_wr && sfr_addr == 8'hB2;
    wire wr_flag = sfr_wr && sfr_addr == 8'hE8;
    wire wr_cmd  = sfr_wr && sfr_addr == 8'h9F;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // Event first, read of the flag register on the next edge
    sequence s_xfer_read;
        transfer_busy_event ##1 (sfr_rd && sfr_addr == 8'hE8);
    endsequence

    property p_page_src;
        wipe_start == FES_WIPE_PAGE |-> $past(wr_trig && sfr_wdata == 8'h55);
    endproperty
    a_page_src: assert property (p_page_src) else $error("page wipe without 55");
    property p_full_src;
        wipe_start == FES_WIPE_FULL |-> $past(wr_trig && sfr_wdata == 8'hAA && debug_en);
    endproperty
    a_full_src: assert property (p_full_src) else $error("bad full wipe start");
    property p_other_none;
        wr_trig && sfr_wdata != 8'h55 && sfr_wdata != 8'hAA |=> wipe_start == FES_WIPE_NONE;
    endproperty
    a_other_none: assert property (p_other_none) else $error("stray wipe start");
    property p_tx_start;
        wr_cmd && sfr_wdata == 8'h01 |=> rom_transmit_start;
    endproperty
    a_tx_start: assert property (p_tx_start) else $error("transmit not started");
    property p_pwe_set;
        wr_ctrl && !irq_global_en && sfr_wdata[0] |=> movx_to_flash;
    endproperty
    a_pwe_set: assert property (p_pwe_set) else $error("write enable not set");
    property p_pwe_done;
        movx_to_flash && flash_byte_done && !wr_ctrl |=> !movx_to_flash;
    endproperty
    a_pwe_done: assert property (p_pwe_done) else $error("write enable kept");
    property p_pwe_lock;
        wr_ctrl && irq_global_en && !movx_to_flash |=> !movx_to_flash;
    endproperty
    a_pwe_lock: assert property (p_pwe_lock) else $error("locked enable changed");
    property p_secure_hold;
        secure_lock |=> secure_lock;
    endproperty
    a_secure_hold: assert property (p_secure_hold) else $error("secure bit dropped");
    property p_kick;
        wr_flag && sfr_wdata[7] |=> watchdog_kick;
    endproperty
    a_kick: assert property (p_kick) else $error("watchdog not kicked");
    property p_raw_live;
        sfr_rd && sfr_addr == 8'hF8 |=> sfr_rdata[6:0] == $past(ext_irq_lines);
    endproperty
    a_raw_live: assert property (p_raw_live) else $error("raw irq read wrong");
    property p_xfer_flag;
        s_xfer_read |=> sfr_rdata[0];
    endproperty
    a_xfer_flag: assert property (p_xfer_flag) else $error("transfer flag not set");
endmodule : fes_regbank_chk

// ==== test/tb_top.sv ====
// ----------------------------------------
// Bench top for the register bank
// ----------------------------------------
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import fes_pkg::*;

    logic       sys_clk = 1'b0;    // 25 MHz core clock
    logic       rst_n = 1'b0;      // Held low at start
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, rv;
    logic       sfr_wr = 1'b0, sfr_rd = 1'b0;
    logic       irq_global_en = 1'b1, debug_en = 1'b0, preboot_active = 1'b0;
    logic       flash_byte_done = 1'b0, transfer_busy_event = 1'b0;
    logic       one_second_event = 1'b0, clock_loss_event = 1'b0;
    logic [6:0] ext_irq_lines = 7'h00, wipe_page;
    fes_wipe_t  wipe_start;
    logic       movx_to_flash, secure_lock, rom_transmit_start, watchdog_kick;
    logic [7:0] serial_rom_byte, serial_rom_command;
    int         err_count = 0, n_tests = 0;

    fes_regbank #(.PAGE_BITS(7)) uut (.*);

    always #20 sys_clk = ~sys_clk;

    // ----------------------------------------
    // Bus cycles and comparison
    // ----------------------------------------
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Inputs move 1 ns after the edge so sampling never races
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #1;
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(posedge sys_clk);
        #1;
        sfr_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        #1;
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(posedge sys_clk);
        #1;
        sfr_rd = 1'b0;
        rv = sfr_rdata;
    endtask : rd

    task automatic t_page();
        rd(8'h94); chk("trig reset", 8'h00, rv);
        wr(8'hB7, 8'hFF); rd(8'hB7); chk("page top", 8'h7F, rv);
        wr(8'hB7, 8'h05);
        wr(8'h94, 8'h55); chk("page go", 8'h01, 8'(wipe_start));
        chk("page num", 8'h05, {1'b0, wipe_page});
        @(posedge sys_clk);
        #1;
        chk("page pulse", 8'h00, 8'(wipe_start));
        rd(8'h94); chk("trig wo", 8'h00, rv);
        wr(8'h94, 8'h55); chk("page reuse", 8'h00, 8'(wipe_start));
        wr(8'hB7, 8'h06);
        wr(8'h94, 8'h12); chk("odd pat", 8'h00, 8'(wipe_start));
    endtask : t_page

    task automatic t_full();
        wr(8'hB2, 8'h02);
        wr(8'h94, 8'hAA); chk("no debug", 8'h00, 8'(wipe_start));
        debug_en = 1'b1;
        wr(8'hB2, 8'h02);
        wr(8'h94, 8'hAA); chk("full go", 8'h03, 8'(wipe_start));
        wr(8'h94, 8'hAA); chk("full reuse", 8'h00, 8'(wipe_start));
    endtask : t_full

    task automatic t_pwe();
        wr(8'hB2, 8'h01); chk("pwe locked", 8'h00, 8'(movx_to_flash));
        irq_global_en = 1'b0;
        wr(8'hB2, 8'h01); chk("pwe set", 8'h01, 8'(movx_to_flash));
        flash_byte_done = 1'b1;
        @(posedge sys_clk);
        #1;
        flash_byte_done = 1'b0;
        chk("pwe done", 8'h00, 8'(movx_to_flash));
        irq_global_en = 1'b1;
        wr(8'hB2, 8'h40); wr(8'hB2, 8'h00); chk("secure", 8'h01, 8'(secure_lock));
    endtask : t_pwe

    // All three flags set together, held over the read, then cleared in two steps
    task automatic t_flags();
        {transfer_busy_event, one_second_event, clock_loss_event} = 3'h7;
        rd(8'hE8); chk("flags set", 8'h83, rv & 8'h83);
        {transfer_busy_event, one_second_event, clock_loss_event} = 3'h0;
        wr(8'hE8, 8'hFE); chk("kick", 8'h01, 8'(watchdog_kick));
        rd(8'hE8); chk("clr xfer", 8'h82, rv & 8'h83);
        wr(8'hE8, 8'h7D); chk("no kick", 8'h00, 8'(watchdog_kick));
        rd(8'hE8); chk("clr all", 8'h00, rv & 8'h83);
    endtask : t_flags

    task automatic t_misc();
        wr(8'h9E, 8'hA5); wr(8'h9F, 8'h01); chk("tx go", 8'h01, 8'(rom_transmit_start));
        chk("rom byte", 8'hA5, serial_rom_byte);
        chk("rom cmd", 8'h01, serial_rom_command);
        ext_irq_lines = 7'h5A;
        rd(8'hF8); chk("raw a", 8'h5A, rv & 8'h7F);
        ext_irq_lines = 7'h25;
        rd(8'hF8); chk("raw b", 8'h25, rv & 8'h7F);
        preboot_active = 1'b1;
        rd(8'hB2); chk("preboot", 8'h80, rv & 8'h80);
    endtask : t_misc

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up

    // Reset for 20 cycles, then the scenarios in turn
    initial
    begin
        repeat (20) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        t_page();
        t_full();
        t_pwe();
        t_flags();
        t_misc();
        wrap_up();
    end
endmodule : tb_top

bind fes_regbank fes_regbank_chk #(.PAGE_BITS(PAGE_BITS)) u_chk (.*);

// ==== verilog/fes_pkg.sv ====
// ----------------------------------------
// Shared types
// ----------------------------------------
package fes_pkg;
    // Erase request kind handed to the flash controller
    typedef enum logic [1:0]
    {
        FES_WIPE_NONE = 2'h0,
        FES_WIPE_PAGE = 2'h1,
        FES_WIPE_FULL = 2'h3
    } fes_wipe_t;
endpackage : fes_pkg

// ==== verilog/fes_regbank.sv ====
`include "fes_regs.svh"

module fes_regbank
    import fes_pkg::*;
#(
    parameter int PAGE_BITS = 7    // Page number width, pages 0..127
)
(
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    input  wire logic [7:0]       sfr_addr,
    input  wire logic [7:0]       sfr_wdata,
    input  wire logic             sfr_wr,
    input  wire logic             sfr_rd,
    output logic      [7:0]       sfr_rdata,
    input  wire logic             irq_global_en,
    input  wire logic             debug_en,
    input  wire logic             preboot_active,
    input  wire logic             flash_byte_done,
    input  wire logic             transfer_busy_event,
    input  wire logic             one_second_event,
    input  wire logic             clock_loss_event,
    input  wire logic [6:0]       ext_irq_lines,
    output fes_pkg::fes_wipe_t    wipe_start,
    output logic [PAGE_BITS-1:0]  wipe_page,
    output logic                  movx_to_flash,
    output logic                  secure_lock,
    output logic [7:0]            serial_rom_byte,
    output logic [7:0]            serial_rom_command,
    output logic                  rom_transmit_start,
    output logic                  watchdog_kick
);
    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    // Every strobe is a plain compare of the full address byte.
    // No partial decode is used, so unmapped addresses in the same
    // neighbourhood never alias onto a register of this bank.
    // Writes are one-cycle pulses from the core; each strobe below is
    // therefore high for exactly the cycle in which the write is taken.
    // The strobes are combinational and are only ever consumed by the
    // clocked processes further down, so they never reach a pin.
    logic wr_trig;     // Write to wipe trigger
    logic wr_byte;     // Write to serial ROM byte
    logic wr_cmd;      // Write to serial ROM command
    logic wr_ctrl;     // Write to store control
    logic wr_page;     // Write to page select
    logic wr_flags;    // Write to flag register

    assign wr_trig  = sfr_wr & (sfr_addr == `FES_ADDR_WIPE_TRIGGER);
    assign wr_byte  = sfr_wr & (sfr_addr == `FES_ADDR_ROM_BYTE);
    assign wr_cmd   = sfr_wr & (sfr_addr == `FES_ADDR_ROM_COMMAND);
    assign wr_ctrl  = sfr_wr & (sfr_addr == `FES_ADDR_STORE_CTRL);
    assign wr_page  = sfr_wr & (sfr_addr == `FES_ADDR_PAGE_SELECT);
    assign wr_flags = sfr_wr & (sfr_addr == `FES_ADDR_EVENT_FLAGS);

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    logic [PAGE_BITS-1:0] page_q;       // Page select value
    logic                 page_fresh_q; // Page written since last page erase
    logic                 pwe_q;        // Program write enable
    logic                 arm_q;        // Full wipe arm
    logic                 secure_q;     // Security lock
    logic [7:0]           rom_byte_q;   // Serial ROM byte
    logic [7:0]           rom_cmd_q;    // Serial ROM command
    logic                 tx_start_q;   // Transmit start pulse
    logic                 kick_q;       // Watchdog kick pulse
    logic [7:0]           rdata_q;      // Read data
    fes_wipe_t            wipe_kind;    // Decoded erase request
    fes_wipe_t            wipe_q;       // Registered erase start

    // ----------------------------------------
    // Erase decode
    // ----------------------------------------
    // The trigger byte is never stored: it is decoded in the cycle of
    // the write and turned into a one-cycle start request. Holding it
    // would risk a second start if the flash controller sampled late.
    // The decoder also sees the freshness of the page number and of the
    // arm bit, so a stale setup can never launch an erase on its own.
    // Limitation: software gets no indication that a pattern was refused;
    // it must check its setup writes itself before writing the trigger.
    // trigger has no storage
    fes_wipe_decode u_decode
    (
        .trig_wr    (wr_trig),
        .trig_data  (sfr_wdata),
        .page_fresh (page_fresh_q),
        .arm_fresh  (arm_q),
        .debug_en   (debug_en),
        .wipe_kind  (wipe_kind)
    );

    // ----------------------------------------
    // Page select and erase start
    // ----------------------------------------
    // Page number held; a page erase consumes its freshness.
    // The page number itself survives the erase and stays readable, but
    // the freshness bit drops, so the same number cannot be erased twice
    // without software writing it again. Only the low bits are stored;
    // the top bit of the byte always reads back as zero.
    // The start request is registered here so that the flash controller
    // sees a clean pulse one cycle after the trigger write.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            page_q       <= '0;
            page_fresh_q <= 1'b0;
            wipe_q       <= FES_WIPE_NONE;
        end
        else
        begin
            wipe_q <= wipe_kind;
            if (wr_page)
            begin
                page_q       <= sfr_wdata[PAGE_BITS-1:0];
                page_fresh_q <= 1'b1;
            end
            else if (wipe_kind == FES_WIPE_PAGE)
                page_fresh_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // Store control bits
    // ----------------------------------------
    // Flash write enable, mass arm and security.
    // A permitted software write to the enable bit beats the byte-done
    // pulse in the same cycle: the later intent of software is kept.
    // While interrupts are on, the enable bit ignores software entirely,
    // so an interrupt handler can never leave stores steered to flash.
    // The arm bit may be cleared by software at any time; a full erase
    // consumes it so that each mass erase needs its own fresh arming.
    // The security bit only ever rises; chip reset is its only clear.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pwe_q    <= 1'b0;
            arm_q    <= 1'b0;
            secure_q <= 1'b0;
        end
        else
        begin
            if (wr_ctrl && !irq_global_en)
                pwe_q <= sfr_wdata[`FES_CTRL_PWE_BIT];
            else if (flash_byte_done)
                pwe_q <= 1'b0;
            if (wr_ctrl)
                arm_q <= sfr_wdata[`FES_CTRL_ARM_BIT];
            else if (wipe_kind == FES_WIPE_FULL)
                arm_q <= 1'b0;
            if (wr_ctrl && sfr_wdata[`FES_CTRL_SECURE_BIT])
                secure_q <= 1'b1;
        end
    end

    // ----------------------------------------
    // Serial ROM registers
    // ----------------------------------------
    // Byte, command, and a start pulse on transmit command.
    // The byte register is written first by software; the command write
    // then launches the send, so the byte is already stable at the start.
    // The pulse lasts one cycle and is not repeated by later writes of
    // other command codes, which are only stored for the interface.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rom_byte_q <= `FES_RST_BYTE;
            rom_cmd_q  <= `FES_RST_BYTE;
            tx_start_q <= 1'b0;
        end
        else
        begin
            if (wr_byte)
                rom_byte_q <= sfr_wdata;
            if (wr_cmd)
                rom_cmd_q <= sfr_wdata;
            tx_start_q <= wr_cmd && (sfr_wdata == `FES_ROM_CMD_TRANSMIT);
        end
    end

    // ----------------------------------------
    // Event flags
    // ----------------------------------------
    logic flag_xfer;     // Transfer event flag
    logic flag_tick;     // Second tick flag
    logic flag_clkloss;  // Clock-loss flag
    logic [2:0] fl_set;  // Set events per flag
    logic [2:0] fl_clr;  // Clear requests per flag
    logic [2:0] fl_q;    // Flag values

    // Software writes the whole byte with ones everywhere except the
    // flags it wants to clear. A zero clears, a one keeps the flag.
    // Bits that hold no flag are ignored on write and read as zero.
    // Each flag is its own small sticky cell so that a hardware event
    // arriving in the same cycle as a clear is never lost.
    // zero bits clear, ones keep
    assign fl_set = {clock_loss_event, one_second_event, transfer_busy_event};
    assign fl_clr = {3{wr_flags}} & ~{sfr_wdata[`FES_FLAG_CLKLOSS_BIT],
                                      sfr_wdata[`FES_FLAG_TICK_BIT],
                                      sfr_wdata[`FES_FLAG_XFER_BIT]};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_flag
            fes_sticky_flag u_flag
            (
                .sys_clk (sys_clk),
                .rst_n   (rst_n),
                .set_evt (fl_set[gi]),
                .clr_req (fl_clr[gi]),
                .flag_q  (fl_q[gi])
            );
        end
    endgenerate

    assign flag_xfer    = fl_q[0];
    assign flag_tick    = fl_q[1];
    assign flag_clkloss = fl_q[2];

    // Watchdog kick pulse on a one in bit 7.
    // Bit 7 has a split meaning: a zero clears the clock-loss flag and a
    // one restarts the watchdog. The usual all-ones write of the flag
    // register therefore also kicks the watchdog, which is intended.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            kick_q <= 1'b0;
        else
            kick_q <= wr_flags & sfr_wdata[`FES_FLAG_CLKLOSS_BIT];
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    logic [7:0] rd_mux;   // Selected read value
    logic [7:0] ctrl_rd;  // Store control read view
    logic [7:0] flag_rd;  // Flag register read view
    logic [7:0] page_rd;  // Page select read view

    assign ctrl_rd = {preboot_active, secure_q, 4'h0, arm_q, pwe_q};
    assign flag_rd = {flag_clkloss, 5'h00, flag_tick, flag_xfer};
    assign page_rd = 8'(page_q);
    assign rd_mux  = (sfr_addr == `FES_ADDR_ROM_BYTE)    ? rom_byte_q :
                     (sfr_addr == `FES_ADDR_ROM_COMMAND) ? rom_cmd_q :
                     (sfr_addr == `FES_ADDR_STORE_CTRL)  ? ctrl_rd :
                     (sfr_addr == `FES_ADDR_PAGE_SELECT) ? page_rd :
                     (sfr_addr == `FES_ADDR_EVENT_FLAGS) ? flag_rd :
                     (sfr_addr == `FES_ADDR_RAW_IRQ)     ? {1'b0, ext_irq_lines} :
                     `FES_RST_BYTE;

    // Read data registered; trigger reads as zero.
    // The read value is captured on the read strobe and then held until
    // the next read, so the core may take it one cycle later at leisure.
    // The raw interrupt levels are captured as they stand in that cycle;
    // nothing is latched for them between reads.
    // Unmapped addresses return zero rather than a stale value.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            rdata_q <= `FES_RST_BYTE;
        else if (sfr_rd)
            rdata_q <= rd_mux;
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Every data output comes straight from a flip-flop, so the flash
    // and serial ROM controllers never see decode glitches.
    // The erase start, transmit start and watchdog kick are one-cycle
    // pulses; the rest are levels that stand until changed.
    assign sfr_rdata          = rdata_q;
    assign wipe_start         = wipe_q;
    assign wipe_page          = page_q;
    assign movx_to_flash      = pwe_q;
    assign secure_lock        = secure_q;
    assign serial_rom_byte    = rom_byte_q;
    assign serial_rom_command = rom_cmd_q;
    assign rom_transmit_start = tx_start_q;
    assign watchdog_kick      = kick_q;
endmodule : fes_regbank

// ==== verilog/fes_regs.svh ====
`ifndef FES_REGS_SVH
`define FES_REGS_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define FES_ADDR_WIPE_TRIGGER  8'h94
`define FES_ADDR_ROM_BYTE      8'h9E
`define FES_ADDR_ROM_COMMAND   8'h9F
`define FES_ADDR_STORE_CTRL    8'hB2
`define FES_ADDR_PAGE_SELECT   8'hB7
`define FES_ADDR_EVENT_FLAGS   8'hE8
`define FES_ADDR_RAW_IRQ       8'hF8

// ----------------------------------------
// Patterns, fields and reset values
// ----------------------------------------
`define FES_PAT_PAGE_WIPE      8'h55
`define FES_PAT_FULL_WIPE      8'hAA
`define FES_CTRL_PWE_BIT       0
`define FES_CTRL_ARM_BIT       1
`define FES_CTRL_SECURE_BIT    6
`define FES_CTRL_PREBOOT_BIT   7
`define FES_FLAG_XFER_BIT      0
`define FES_FLAG_TICK_BIT      1
`define FES_FLAG_CLKLOSS_BIT   7
`define FES_RST_BYTE           8'h00
`define FES_PAGE_MAX           8'h7F
`define FES_ROM_CMD_TRANSMIT   8'h01

`endif

// ==== verilog/fes_sticky_flag.sv ====
`include "fes_regs.svh"

// ----------------------------------------
// One sticky flag: set wins over clear
// ----------------------------------------
module fes_sticky_flag
(
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic set_evt,
    input  wire logic clr_req,
    output logic      flag_q
);
    logic flag_d; // Next flag value

    // Hardware event beats a simultaneous software clear
    assign flag_d = set_evt | (flag_q & ~clr_req);

    // Flag storage
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            flag_q <= 1'b0;
        else
            flag_q <= flag_d;
    end
endmodule : fes_sticky_flag

// ==== verilog/fes_wipe_decode.sv ====
`include "fes_regs.svh"

// ----------------------------------------
// Wipe trigger pattern decoder
// ----------------------------------------
module fes_wipe_decode
    import fes_pkg::*;
(
    input  wire logic             trig_wr,
    input  wire logic [7:0]       trig_data,
    input  wire logic             page_fresh,
    input  wire logic             arm_fresh,
    input  wire logic             debug_en,
    output fes_pkg::fes_wipe_t    wipe_kind
);
    logic is_page; // Page pattern seen with a fresh page number
    logic is_full; // Full pattern seen, armed, debug open

    assign is_page = trig_wr & (trig_data == `FES_PAT_PAGE_WIPE) & page_fresh;
    assign is_full = trig_wr & (trig_data == `FES_PAT_FULL_WIPE) & arm_fresh & debug_en;
    assign wipe_kind = is_full ? FES_WIPE_FULL : (is_page ? FES_WIPE_PAGE : FES_WIPE_NONE);
endmodule : fes_wipe_decode
